// *** src/fei_pkg.sv ***
// Constants for the flash event interrupt logic
package fei_pkg;
	localparam int FEI_DW = 16;
	localparam int FEI_AW = 8;
	localparam int FEI_SYS_N = 4;
	// Register byte offsets
	localparam logic [7:0] FEI_OFF_EN = 8'h00;
	localparam logic [7:0] FEI_OFF_FLG = 8'h04;
	localparam logic [7:0] FEI_OFF_STS = 8'h08;
	localparam logic [7:0] FEI_OFF_CLR = 8'h0c;
	localparam logic [7:0] FEI_OFF_IEN = 8'h10;
	// Field positions in both event registers
	localparam int FEI_B_PIN = 15;
	localparam int FEI_B_RDY = 4;
	localparam int FEI_B_POR = 2;
	localparam int FEI_B_ECC2 = 1;
	localparam int FEI_B_ECC1 = 0;
	// System status bit positions
	localparam int FEI_S_ECC1 = 0;
	localparam int FEI_S_ECC2 = 1;
	localparam int FEI_S_RDY = 2;
	localparam int FEI_S_PIN = 3;
	// Writable enable bits and event-driven flag bits
	localparam logic [15:0] FEI_EN_RW = 16'h8013;
	localparam logic [15:0] FEI_EV_MASK = 16'h0013;
	// Reset values
	localparam logic [15:0] FEI_EN_RST = 16'hffff;
	localparam logic [15:0] FEI_FLG_HW_RST = 16'hffff;
	localparam logic [15:0] FEI_FLG_POR_RST = 16'hfffb;
	localparam logic [3:0] FEI_SYS_RST = 4'h0;
	localparam logic [1:0] FEI_SYNC_RST = 2'h3;
endpackage

// *** src/fei_flash_event_irq.sv ***
// Flash event interrupt logic with APB register access
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
module fei_flash_event_irq
	import fei_pkg::*;
(
	// Clock and power-on reset
	input wire logic clock,
	input wire logic rst_b,
	// Hardware reset pin, asynchronous
	input wire logic hw_reset_b,
	// Internal event pulses
	input wire logic ready_evt,
	input wire logic ecc2_evt,
	input wire logic ecc1_evt,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [FEI_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Open-drain interrupt pin
	output logic int_pin_out,
	output logic int_pin_oe,
	// System interrupt
	output logic irq
);

	typedef struct packed {
		logic [FEI_DW-1:0] en;
		logic [FEI_DW-1:0] flg;
		logic [FEI_SYS_N-1:0] sts;
		logic [FEI_SYS_N-1:0] ien;
		logic [1:0] sync;
		logic pin;
		logic [31:0] rdata;
	} fei_state_t;

	fei_state_t s_q;
	fei_state_t s_d;

	logic hwr;
	logic wr_acc;
	logic rd_setup;
	logic [FEI_DW-1:0] ev_raw;
	logic [FEI_DW-1:0] ev_hit;
	logic pin_drive;
	logic wr_en;
	logic wr_flg;
	logic wr_clr;
	logic wr_ien;
	logic [FEI_SYS_N-1:0] sts_set;

	function automatic logic mapped(input logic [FEI_AW-1:0] a);
		mapped = (a == FEI_OFF_EN) || (a == FEI_OFF_FLG) ||
			(a == FEI_OFF_STS) || (a == FEI_OFF_CLR) ||
			(a == FEI_OFF_IEN);
	endfunction

	function automatic logic [31:0] rd_mux(input fei_state_t s,
		input logic [FEI_AW-1:0] a);
		rd_mux = 32'h0;
		case (a)
			FEI_OFF_EN: rd_mux = {16'h0, s.en};
			FEI_OFF_FLG: rd_mux = {16'h0, s.flg};
			FEI_OFF_STS: rd_mux = {28'h0, s.sts};
			FEI_OFF_IEN: rd_mux = {28'h0, s.ien};
			default: rd_mux = 32'h0;
		endcase
	endfunction

	// Zero-wait slave; read data captured in setup phase
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign wr_acc = psel & penable & pwrite & mapped(paddr);
	assign rd_setup = psel & ~penable;
	assign hwr = ~s_q.sync[1];

	// Write strobes per register
	assign wr_en = wr_acc & (paddr == FEI_OFF_EN);
	assign wr_flg = wr_acc & (paddr == FEI_OFF_FLG);
	assign wr_clr = wr_acc & (paddr == FEI_OFF_CLR);
	assign wr_ien = wr_acc & (paddr == FEI_OFF_IEN);

	assign ev_raw = {11'h0, ready_evt, 2'b00, ecc2_evt, ecc1_evt};
	assign ev_hit = ev_raw & ~s_q.en & FEI_EV_MASK;

	// drive while the pin is enabled and any enabled flag is low
	assign pin_drive = ~s_q.en[FEI_B_PIN] &
		(|(~s_q.flg & ~s_q.en & FEI_EV_MASK));

	// Status set sources, event sources quiet during hardware reset
	assign sts_set[FEI_S_ECC1] = ev_hit[FEI_B_ECC1] & ~hwr;
	assign sts_set[FEI_S_ECC2] = ev_hit[FEI_B_ECC2] & ~hwr;
	assign sts_set[FEI_S_RDY] = ev_hit[FEI_B_RDY] & ~hwr;
	assign sts_set[FEI_S_PIN] = pin_drive & ~s_q.pin;

	always_comb begin
		s_d = s_q;
		s_d.sync = {s_q.sync[0], hw_reset_b};
		s_d.pin = pin_drive;
		if (rd_setup) begin
			s_d.rdata = rd_mux(s_q, paddr);
		end
		if (hwr) begin
			s_d.en = FEI_EN_RST;
			s_d.flg = FEI_FLG_HW_RST;
		end else begin
			if (wr_en) begin
				s_d.en = pwdata[15:0] | ~FEI_EN_RW;
				// disabling a channel sets its flag
				s_d.flg = s_q.flg | (pwdata[15:0] & FEI_EV_MASK);
				// POR flag left to flag writes
				if (pwdata[FEI_B_PIN]) begin
					s_d.flg = s_q.flg | FEI_FLG_POR_RST;
				end
			end
			if (wr_flg) begin
				s_d.flg = s_q.flg | pwdata[15:0];
			end
			// events clear flags, winning over writes
			s_d.flg = s_d.flg & ~ev_hit;
		end
		if (wr_clr) begin
			s_d.sts = s_q.sts & ~pwdata[FEI_SYS_N-1:0];
		end
		if (wr_ien) begin
			s_d.ien = pwdata[FEI_SYS_N-1:0];
		end
		// System status: set wins over clear
		s_d.sts = s_d.sts | sts_set;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_q.en <= FEI_EN_RST;
			s_q.flg <= FEI_FLG_POR_RST;
			s_q.sts <= FEI_SYS_RST;
			s_q.ien <= FEI_SYS_RST;
			s_q.sync <= FEI_SYNC_RST;
			s_q.pin <= 1'b0;
			s_q.rdata <= 32'h0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	// open drain: only ever drives low
	assign int_pin_out = 1'b0;
	assign int_pin_oe = pin_drive;
	assign irq = |(s_q.sts & s_q.ien);

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	sequence seq_en_write;
		wr_acc && paddr == FEI_OFF_EN && !hwr;
	endsequence

	sequence seq_flg_write;
		wr_acc && paddr == FEI_OFF_FLG && !hwr;
	endsequence

	sequence seq_no_events;
		!ready_evt && !ecc1_evt && !ecc2_evt;
	endsequence

	sequence seq_ecc1_hit;
		ecc1_evt && !hwr && !s_q.en[FEI_B_ECC1];
	endsequence

	sequence seq_ecc2_hit;
		ecc2_evt && !hwr && !s_q.en[FEI_B_ECC2];
	endsequence

	sequence seq_rdy_hit;
		ready_evt && !hwr && !s_q.en[FEI_B_RDY];
	endsequence

	sequence seq_quiet;
		!wr_acc && !hwr;
	endsequence

	a_pin_gate_off: assert property (
		s_q.en[FEI_B_PIN] |-> !int_pin_oe)
		else $error("Pin driven while output disabled");

	a_ready_sets_pin: assert property (
		ready_evt && !hwr && !s_q.en[FEI_B_RDY] && !s_q.en[FEI_B_PIN]
		&& !wr_acc |=> int_pin_oe)
		else $error("Enabled ready event did not drive pin");

	a_ecc_masked: assert property (
		ecc1_evt && s_q.en[FEI_B_ECC1] && s_q.flg[FEI_B_ECC1]
		|=> s_q.flg[FEI_B_ECC1])
		else $error("Masked ECC event changed flag");

	a_flag_write_sets: assert property (
		seq_flg_write and (pwdata[FEI_B_ECC2] && !ecc2_evt)
		|=> s_q.flg[FEI_B_ECC2])
		else $error("Flag write did not set bit");

	a_flag_fall_cause: assert property (
		$fell(s_q.flg[FEI_B_ECC2]) |-> $past(ecc2_evt))
		else $error("Flag cleared without event");

	a_global_clear: assert property (
		seq_en_write and seq_no_events and pwdata[FEI_B_PIN]
		|=> (s_q.flg | ~FEI_FLG_POR_RST) == FEI_FLG_HW_RST)
		else $error("Global disable did not set flags");

	a_chan_disable: assert property (
		seq_en_write and (pwdata[FEI_B_RDY] && !ready_evt)
		|=> s_q.flg[FEI_B_RDY] && s_q.en[FEI_B_RDY])
		else $error("Channel disable did not set flag");

	a_hw_reset_defaults: assert property (
		hwr |=> s_q.en == FEI_EN_RST && s_q.flg == FEI_FLG_HW_RST
		##0 !int_pin_oe)
		else $error("Hardware reset defaults wrong");

	a_por_flag_hold: assert property (
		$rose(s_q.flg[FEI_B_POR]) |->
		$past(hwr) || $past(wr_acc && paddr == FEI_OFF_FLG))
		else $error("POR flag set without cause");

	a_por_no_pin: assert property (
		!s_q.flg[FEI_B_POR] && s_q.flg[FEI_B_RDY] && s_q.flg[FEI_B_ECC2]
		&& s_q.flg[FEI_B_ECC1] |-> !int_pin_oe)
		else $error("POR flag drove pin");

	a_reserved_ones: assert property (
		(s_q.en | FEI_EN_RW) == FEI_EN_RST &&
		s_q.flg[15:5] == 11'h7ff && s_q.flg[3])
		else $error("Reserved bit reads zero");

	a_ecc1_records: assert property (
		seq_ecc1_hit
		|=> !s_q.flg[FEI_B_ECC1])
		else $error("Enabled 1-bit ECC event not recorded");

	a_ecc2_records: assert property (
		seq_ecc2_hit
		|=> !s_q.flg[FEI_B_ECC2])
		else $error("Enabled 2-bit ECC event not recorded");

	a_ready_records: assert property (
		seq_rdy_hit
		|=> !s_q.flg[FEI_B_RDY])
		else $error("Enabled ready event not recorded");

	a_ecc2_masked: assert property (
		ecc2_evt && s_q.en[FEI_B_ECC2] && s_q.flg[FEI_B_ECC2]
		|=> s_q.flg[FEI_B_ECC2])
		else $error("Masked 2-bit ECC event changed flag");

	a_ready_masked: assert property (
		ready_evt && s_q.en[FEI_B_RDY] && s_q.flg[FEI_B_RDY]
		|=> s_q.flg[FEI_B_RDY])
		else $error("Masked ready event changed flag");

	a_ecc1_sets_pin: assert property (
		seq_ecc1_hit and (!s_q.en[FEI_B_PIN] && !wr_acc)
		|=> int_pin_oe)
		else $error("Enabled 1-bit ECC event did not drive pin");

	a_ecc2_sets_pin: assert property (
		seq_ecc2_hit and (!s_q.en[FEI_B_PIN] && !wr_acc)
		|=> int_pin_oe)
		else $error("Enabled 2-bit ECC event did not drive pin");

	a_ecc1_fall_cause: assert property (
		$fell(s_q.flg[FEI_B_ECC1])
		|-> $past(ecc1_evt))
		else $error("1-bit ECC flag cleared without event");

	a_ready_fall_cause: assert property (
		$fell(s_q.flg[FEI_B_RDY])
		|-> $past(ready_evt))
		else $error("Ready flag cleared without event");

	a_quiet_no_fall: assert property (
		seq_no_events
		|=> (s_q.flg & $past(s_q.flg)) == $past(s_q.flg))
		else $error("Flag bit fell without event");

	a_por_stays_set: assert property (
		s_q.flg[FEI_B_POR]
		|=> s_q.flg[FEI_B_POR])
		else $error("POR flag cleared after being set");

	a_pin_held: assert property (
		seq_quiet and int_pin_oe
		|=> int_pin_oe)
		else $error("Pin released with no clearing action");

	a_pin_stays_off: assert property (
		seq_quiet and seq_no_events and !int_pin_oe
		|=> !int_pin_oe)
		else $error("Pin driven with no event");

	a_global_pin_off: assert property (
		seq_en_write and pwdata[FEI_B_PIN]
		|=> !int_pin_oe)
		else $error("Pin driven after global disable");

	a_ecc1_disable: assert property (
		seq_en_write and (pwdata[FEI_B_ECC1] && !ecc1_evt)
		|=> s_q.flg[FEI_B_ECC1] && s_q.en[FEI_B_ECC1])
		else $error("1-bit ECC disable did not set flag");

	a_ecc2_disable: assert property (
		seq_en_write and (pwdata[FEI_B_ECC2] && !ecc2_evt)
		|=> s_q.flg[FEI_B_ECC2] && s_q.en[FEI_B_ECC2])
		else $error("2-bit ECC disable did not set flag");

	a_en_write_value: assert property (
		seq_en_write
		|=> (s_q.en & FEI_EN_RW) == ($past(pwdata[15:0]) & FEI_EN_RW))
		else $error("Enable write not stored");

	a_hw_blocks_event: assert property (
		hwr && ecc1_evt
		|=> s_q.flg[FEI_B_ECC1])
		else $error("Event recorded during hardware reset");

	a_sts_records: assert property (
		seq_ecc2_hit
		|=> s_q.sts[FEI_S_ECC2])
		else $error("Status bit not set by event");

	a_sts_sticky: assert property (
		s_q.sts[FEI_S_RDY] && !wr_clr
		|=> s_q.sts[FEI_S_RDY])
		else $error("Status bit lost without clear");

	a_flag_sticky: assert property (
		seq_quiet and !s_q.flg[FEI_B_RDY]
		|=> !s_q.flg[FEI_B_RDY])
		else $error("Ready flag set without clearing action");

	a_por_write_sets: assert property (
		seq_flg_write and pwdata[FEI_B_POR]
		|=> s_q.flg[FEI_B_POR])
		else $error("Flag write did not set POR flag");

	a_global_keeps_por: assert property (
		seq_en_write and pwdata[FEI_B_PIN]
		|=> $stable(s_q.flg[FEI_B_POR]))
		else $error("Global disable changed POR flag");

	a_pin_edge_sts: assert property (
		$rose(int_pin_oe)
		|=> s_q.sts[FEI_S_PIN])
		else $error("Pin assertion not recorded in status");

endmodule

// *** tb/fei_host_pin.sv ***
// Host side of the open-drain interrupt pin
`timescale 1ns/1ps
module fei_host_pin (
	// Pin drive from the device
	input wire logic pin_out,
	input wire logic pin_oe,
	// Level seen by the host
	output logic pin_level
);
	assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule

// *** tb/tb_flash_event_interrupt_logic.sv ***
// Testbench for the flash event interrupt logic
`timescale 1ns/1ps
module tb_flash_event_interrupt_logic;
	import fei_pkg::*;
	logic clock, rst_b, hw_reset_b, psel, penable, pwrite;
	logic ready_evt, ecc2_evt, ecc1_evt, pready, pslverr;
	logic int_pin_out, int_pin_oe, irq, pin, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int mismatches = 0;
	int total_checks = 0;
	fei_flash_event_irq dut_u (.clock(clock), .rst_b(rst_b),
		.hw_reset_b(hw_reset_b), .ready_evt(ready_evt),
		.ecc2_evt(ecc2_evt), .ecc1_evt(ecc1_evt), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .int_pin_out(int_pin_out),
		.int_pin_oe(int_pin_oe), .irq(irq));
	fei_host_pin host_u (.pin_out(int_pin_out), .pin_oe(int_pin_oe),
		.pin_level(pin));
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input string s, input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20) begin
			mismatches++;
			complete_run();
		end
	endtask
	task rd(input logic [7:0] a, input string s, input logic [31:0] e);
		apb(0, a, 0);
		chk(s, r, e);
	endtask
	task pulse(input int k, input logic p);
		@(posedge clock);
		{ready_evt, ecc2_evt, ecc1_evt} <= 3'(1 << k);
		@(posedge clock);
		{ready_evt, ecc2_evt, ecc1_evt} <= 3'h0;
		#1 chk("pin", 32'(pin), 32'(p));
	endtask
	task t_reset;
		rd(FEI_OFF_EN, "en", 32'h0000ffff);
		rd(FEI_OFF_FLG, "flg", 32'h0000fffb);
		chk("pin", 32'(pin), 1);
		apb(1, FEI_OFF_EN, 32'h0000ffff);
		rd(FEI_OFF_FLG, "flg", 32'h0000fffb);
	endtask
	task t_flags;
		apb(1, FEI_OFF_EN, 32'h00007fec);
		#1 chk("pin", 32'(pin), 1);
		apb(1, FEI_OFF_FLG, 32'h00000004);
		rd(FEI_OFF_FLG, "flg", 32'h0000ffff);
		pulse(0, 0);
		pulse(1, 0);
		// host reads the flags after pin low
		rd(FEI_OFF_FLG, "flg", 32'h0000fffc);
		apb(1, FEI_OFF_FLG, 32'h00000001);
		rd(FEI_OFF_FLG, "flg", 32'h0000fffd);
		chk("pin", 32'(pin), 0);
		apb(1, FEI_OFF_EN, 32'h00007fee);
		rd(FEI_OFF_FLG, "flg", 32'h0000ffff);
		chk("pin", 32'(pin), 1);
	endtask
	task t_gate;
		apb(1, FEI_OFF_EN, 32'h00007fff);
		pulse(2, 1);
		apb(1, FEI_OFF_EN, 32'h00007fef);
		pulse(2, 0);
		rd(FEI_OFF_FLG, "flg", 32'h0000ffef);
		apb(1, FEI_OFF_EN, 32'h0000ffec);
		rd(FEI_OFF_FLG, "flg", 32'h0000ffff);
		pulse(0, 1);
	endtask
	task t_irq;
		apb(1, FEI_OFF_IEN, 32'h0000000f);
		#1 chk("irq", 32'(irq), 1);
		apb(1, FEI_OFF_CLR, 32'h0000000f);
		#1 chk("irq", 32'(irq), 0);
		rd(8'h20, "bad", 0);
		chk("err", 32'(err), 1);
	endtask
	task t_hw;
		apb(1, FEI_OFF_EN, 32'h00007ffe);
		#1 chk("pin", 32'(pin), 0);
		@(posedge clock);
		hw_reset_b <= 0;
		repeat (5) @(posedge clock);
		hw_reset_b <= 1;
		repeat (3) @(posedge clock);
		rd(FEI_OFF_EN, "en", 32'h0000ffff);
		rd(FEI_OFF_FLG, "flg", 32'h0000ffff);
		chk("pin", 32'(pin), 1);
	endtask
	initial begin
		{rst_b, psel, penable, pwrite, ready_evt, ecc2_evt, ecc1_evt} = 0;
		hw_reset_b = 1;
		paddr = 0;
		pwdata = 0;
		repeat (4) @(posedge clock);
		rst_b <= 1;
		t_reset();
		t_flags();
		t_gate();
		t_irq();
		t_hw();
		complete_run();
	end
endmodule
